//--- hdl/programmable_counter_array.sv
// Purpose: shared 16-bit counter with five compare/capture modules
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   irq is a level; wdt_reset is a one-cycle pulse
//
// The placing of the registers and the Wishbone register port were chosen for this implementation.
`default_nettype none
module programmable_counter_array
  import pca_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                wb_cyc,
  input  wire logic                wb_stb,
  input  wire logic                wb_we,
  input  wire logic [7:0]          wb_adr,
  input  wire logic [3:0]          wb_sel,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack,
  input  wire logic                idle,
  input  wire logic                timer0_overflow,
  input  wire logic                external_count_input,
  input  wire logic [num_chan-1:0] module_io_in,
  output logic [num_chan-1:0]      module_io_out,
  output logic [num_chan-1:0]      module_io_oe,
  output logic                     irq,
  output logic                     wdt_reset
);
  pca_s s;
  pca_s next_s;

  logic [num_chan:0] rise;
  logic [num_chan:0] fall;
  logic              tick;

  // slot decode shared by the read and write paths
  function automatic logic chan_hit(input logic [7:0] a, input int i);
    logic [7:0] base;
    base = chan_base_addr + 8'(i * 16);
    return a[7:4] == base[7:4];
  endfunction

  // pin 0 is the external count input, pins 1..5 the module pins
  pin_sync u_ext_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin      (external_count_input), // see R7
    .level    (),
    .rise     (rise[0]),
    .fall     (fall[0])
  );

  genvar g;
  generate
    for (g = 0; g < num_chan; g++) begin : g_sync
      pin_sync u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (module_io_in[g]), // see R7
        .level    (),
        .rise     (rise[g+1]),
        .fall     (fall[g+1])
      );
    end
  endgenerate

  count_source u_src (
    .core_clk        (core_clk),
    .rst             (rst),
    .src             (s.src),
    .timer0_overflow (timer0_overflow),
    .ext_rise        (rise[0]),
    .tick            (tick)
  );

  logic                access;
  logic                wr;
  logic                running;
  logic                wrap;
  logic                ovf_set;
  logic [num_chan-1:0] ev_set;
  logic [num_chan-1:0] match;
  logic [num_chan-1:0] cap;
  logic [31:0]         rd;

  always_comb begin
    next_s = s;
    access = wb_cyc & wb_stb & ~s.ack;
    wr = access & wb_we & wb_sel[0];
    next_s.ack = access;
    next_s.cnt_moved = 1'b0;
    next_s.wdt_reset = 1'b0;
    wrap = 1'b0;
    ovf_set = 1'b0;
    ev_set = '0;
    match = '0;
    cap = '0;
    rd = '0;

    // halting in idle costs nothing when idle_stop is clear
    running = s.counter_run & ~(idle & s.idle_stop); // see R11 see R15 see R8
    if (tick && running) begin // see R2
      next_s.cnt = s.cnt + 16'h0001;
      next_s.cnt_moved = 1'b1;
      ovf_set = (s.cnt == cnt_last); // see R10
      wrap = (s.cnt[7:0] == low_last);
    end

    for (int i = 0; i < num_chan; i++) begin
      // match is judged once per new count value, not every cycle
      match[i] = s.cnt_moved & s.ch[i].mode.ecom & ~s.ch[i].mode.pwm
               & (s.cnt == {s.ch[i].high, s.ch[i].low});
      cap[i] = (s.ch[i].mode.capp & rise[i+1])
             | (s.ch[i].mode.capn & fall[i+1]); // see R3 see R20
      if (cap[i]) begin // see R16
        next_s.ch[i].low = s.cnt[7:0];
        next_s.ch[i].high = s.cnt[15:8];
      end
      ev_set[i] = cap[i] | (match[i] & s.ch[i].mode.mat); // see R13
      if (match[i] && s.ch[i].mode.tog) begin // see R3
        next_s.ch[i].pin = ~s.ch[i].pin;
      end
      if (s.ch[i].mode.pwm && s.ch[i].mode.ecom) begin // see R3
        next_s.ch[i].pin = (s.cnt[7:0] >= s.ch[i].low);
        if (wrap) begin // see R17
          next_s.ch[i].low = s.ch[i].high;
        end
      end
      // pins not in an output mode stay plain port bits
      next_s.pin_oe[i] = s.ch[i].mode.ecom
                       & (s.ch[i].mode.tog | s.ch[i].mode.pwm); // see R7
    end

    // module 4 only; an internal pulse, no pin is driven
    if (s.watchdog_enable && match[num_chan-1]) begin // see R4 see R9
      next_s.wdt_reset = 1'b1; // see R18
    end

    if (wr) begin
      case (wb_adr)
        mode_reg_addr: begin
          next_s.idle_stop = wb_dat_i[idle_stop_bit]; // see R8
          next_s.watchdog_enable = wb_dat_i[wdt_enable_bit]; // see R9
          next_s.src = count_src_e'(wb_dat_i[src_lsb +: 2]);
          next_s.overflow_irq_enable = wb_dat_i[ovf_irq_bit];
        end
        ctrl_reg_addr: begin
          next_s.counter_overflow_flag = wb_dat_i[ovf_flag_bit]; // see R12
          next_s.counter_run = wb_dat_i[run_bit]; // see R11
          next_s.module_event_flags = wb_dat_i[num_chan-1:0]; // see R14
        end
        cnt_lo_addr: begin
          next_s.cnt[7:0] = wb_dat_i[7:0];
        end
        cnt_hi_addr: begin
          next_s.cnt[15:8] = wb_dat_i[7:0];
        end
        default: begin
          for (int i = 0; i < num_chan; i++) begin
            if (chan_hit(wb_adr, i)) begin
              case (wb_adr[3:0])
                chan_mode_off: next_s.ch[i].mode = wb_dat_i[6:0];
                chan_low_off:  next_s.ch[i].low = wb_dat_i[7:0];
                chan_high_off: next_s.ch[i].high = wb_dat_i[7:0];
                default: ;
              endcase
            end
          end
        end
      endcase
    end

    // a hardware set in the clearing cycle wins over the clear
    next_s.counter_overflow_flag = next_s.counter_overflow_flag
                                 | ovf_set; // see R10 see R12
    next_s.module_event_flags = next_s.module_event_flags
                              | ev_set; // see R13 see R14

    next_s.irq = next_s.counter_overflow_flag
               & next_s.overflow_irq_enable; // see R10 see R6
    for (int i = 0; i < num_chan; i++) begin
      if (next_s.module_event_flags[i] && next_s.ch[i].mode.eccf) begin
        next_s.irq = 1'b1; // see R5 see R6
      end
    end

    case (wb_adr)
      mode_reg_addr: begin
        rd[idle_stop_bit] = s.idle_stop;
        rd[wdt_enable_bit] = s.watchdog_enable;
        rd[src_lsb +: 2] = s.src;
        rd[ovf_irq_bit] = s.overflow_irq_enable;
      end
      ctrl_reg_addr: begin
        rd[ovf_flag_bit] = s.counter_overflow_flag;
        rd[run_bit] = s.counter_run;
        rd[num_chan-1:0] = s.module_event_flags;
      end
      cnt_lo_addr: rd[7:0] = s.cnt[7:0];
      cnt_hi_addr: rd[7:0] = s.cnt[15:8];
      default: begin
        for (int i = 0; i < num_chan; i++) begin
          if (chan_hit(wb_adr, i)) begin
            case (wb_adr[3:0])
              chan_mode_off: rd[6:0] = s.ch[i].mode;
              chan_low_off:  rd[7:0] = s.ch[i].low;
              chan_high_off: rd[7:0] = s.ch[i].high;
              default: ;
            endcase
          end
        end
      end
    endcase
    next_s.dat = access ? rd : '0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.cnt <= cnt_reset;
    end else begin
      s <= next_s;
    end
  end

  assign wb_dat_o = s.dat;
  assign wb_ack = s.ack;
  assign module_io_out = {s.ch[4].pin, s.ch[3].pin, s.ch[2].pin,
                          s.ch[1].pin, s.ch[0].pin};
  assign module_io_oe = s.pin_oe;
  assign irq = s.irq;
  assign wdt_reset = s.wdt_reset;
endmodule
`default_nettype wire

//--- hdl/pca_pkg.sv
// Purpose: shared constants and carriers for the programmable counter array
// Assumes: 32-bit classic wishbone, byte-wide registers in bits 7:0
// Notes:   register offsets are byte addresses
// Operation
// R1: counter clocked by clk/6, clk/2, timer 0 overflow or external input
// R2: one shared 16-bit counter is the time base for all five modules
// R3: each module: edge capture, software timer, high-speed output or pwm
// R4: only module 4 may act as a watchdog on the shared counter
// R5: capture, timer and high-speed output events can request an interrupt
// R6: five module requests plus overflow merge onto one interrupt line
// R7: external count on port 1 bit 2, modules on bits 3 to 7
// R8: an idle-stop bit lets the array halt while the processor idles
// R9: a watchdog enable bit switches module 4 watchdog on or off
// R10: overflow always sets the flag; it interrupts only when enabled
// R11: the counter runs only while the run bit is set
// R12: hardware never clears the overflow flag; software writes control
// R13: hardware sets a module flag on compare match or capture
// R14: software clears module flags by writing control; hardware never does
// R15: idle with idle-stop one halts the array; zero keeps it running
// R16: a selected pin edge in capture copies the counter to the module
// R17: pwm reloads low compare from high byte when low count wraps
// R18: watchdog match gives an internal reset, not the external pin
// R19: source select 00 clk/6, 01 clk/2, 10 timer 0, 11 external
// R20: pins are synchronised; counting and capture act on transitions
`default_nettype none
package pca_pkg;
  localparam int num_chan = 5;
  localparam logic [7:0] mode_reg_addr  = 8'h00;
  localparam logic [7:0] ctrl_reg_addr  = 8'h04;
  localparam logic [7:0] cnt_lo_addr    = 8'h08;
  localparam logic [7:0] cnt_hi_addr    = 8'h0c;
  localparam logic [7:0] chan_base_addr = 8'h20;
  localparam logic [3:0] chan_mode_off  = 4'h0;
  localparam logic [3:0] chan_low_off   = 4'h4;
  localparam logic [3:0] chan_high_off  = 4'h8;
  // mode register bit positions
  localparam int idle_stop_bit  = 7;
  localparam int wdt_enable_bit = 6;
  localparam int src_lsb        = 1;
  localparam int ovf_irq_bit    = 0;
  // control register bit positions
  localparam int ovf_flag_bit   = 7;
  localparam int run_bit        = 6;
  localparam logic [2:0] div6_last = 3'h5;
  localparam logic [2:0] div2_last = 3'h1;
  localparam logic [15:0] cnt_reset = 16'h0000;
  localparam logic [15:0] cnt_last  = 16'hffff;
  localparam logic [7:0]  low_last  = 8'hff;

  typedef enum logic [1:0] {
    src_div6   = 2'h0,
    src_div2   = 2'h1,
    src_timer0 = 2'h2,
    src_ext    = 2'h3
  } count_src_e;

  typedef struct packed {
    logic ecom;
    logic capp;
    logic capn;
    logic mat;
    logic tog;
    logic pwm;
    logic eccf;
  } chan_mode_s;

  typedef struct packed {
    chan_mode_s mode;
    logic [7:0] low;
    logic [7:0] high;
    logic       pin;
  } chan_s;

  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
    logic       rise;
    logic       fall;
  } sync_s;

  typedef struct packed {
    logic [2:0] div;
    logic       tick;
  } div_s;

  typedef struct packed {
    logic                      idle_stop;
    logic                      watchdog_enable;
    count_src_e                src;
    logic                      overflow_irq_enable;
    logic                      counter_overflow_flag;
    logic                      counter_run;
    logic [num_chan-1:0]       module_event_flags;
    logic [15:0]               cnt;
    logic                      cnt_moved;
    chan_s [num_chan-1:0]      ch;
    logic [num_chan-1:0]       pin_oe;
    logic                      irq;
    logic                      wdt_reset;
    logic                      ack;
    logic [31:0]               dat;
  } pca_s;
endpackage
`default_nettype wire

//--- hdl/pin_sync.sv
// Purpose: bring a port pin into the core clock domain
// Assumes: pin is asynchronous to core_clk
// Notes:   an edge counts once the second and third stages agree
`default_nettype none
module pin_sync
  import pca_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s = s;
    next_s.sh = {s.sh[1:0], pin};
    next_s.rise = 1'b0;
    next_s.fall = 1'b0;
    // stage 0 only feeds stage 1; decisions use stages 1 and 2
    if (s.sh[1] == s.sh[2] && s.sh[2] != s.lvl) begin // see R20
      next_s.lvl = s.sh[2];
      next_s.rise = s.sh[2];
      next_s.fall = ~s.sh[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.lvl;
  assign rise = s.rise;
  assign fall = s.fall;
endmodule
`default_nettype wire

//--- hdl/count_source.sv
// Purpose: one-cycle count ticks for the shared counter
// Assumes: timer0_overflow is a one-cycle pulse on core_clk
// Notes:   the divider free-runs so a source switch needs no restart
`default_nettype none
module count_source
  import pca_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire count_src_e src,
  input  wire logic       timer0_overflow,
  input  wire logic       ext_rise,
  output logic            tick
);
  div_s s;
  div_s next_s;
  logic [2:0] last;

  always_comb begin
    next_s = s;
    last = (src == src_div6) ? div6_last : div2_last;
    next_s.div = (s.div >= last) ? 3'h0 : s.div + 3'h1;
    case (src) // see R19
      src_div6:   next_s.tick = (s.div >= last); // see R1
      src_div2:   next_s.tick = (s.div >= last); // see R1
      src_timer0: next_s.tick = timer0_overflow; // see R1
      src_ext:    next_s.tick = ext_rise; // see R20
      default:    next_s.tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
endmodule
`default_nettype wire

//--- tb/pca_props.sv
// Purpose: bus and pulse checks at the array ports
// Assumes: one clock, synchronous active-high reset
// Notes:   counts and flags are judged by the bench
`default_nettype none
module pca_props
  import pca_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                wb_cyc,
  input wire logic                wb_stb,
  input wire logic                wb_we,
  input wire logic [7:0]          wb_adr,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack,
  input wire logic                irq,
  input wire logic                wdt_reset,
  input wire logic [num_chan-1:0] module_io_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_req;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_hole;
    s_req ##0 (!wb_we && wb_adr == 8'h10);
  endsequence
  property p_answer;
    s_req |=> wb_ack ##1 !wb_ack;
  endproperty
  property p_dat_idle;
    !wb_ack |-> wb_dat_o == 32'h0;
  endproperty
  property p_dat_byte;
    wb_ack |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  property p_hole;
    s_hole |=> wb_dat_o == 32'h0;
  endproperty
  property p_ack_cause;
    wb_ack |-> $past(wb_cyc && wb_stb);
  endproperty
  property p_wdt_pulse;
    wdt_reset |=> !wdt_reset;
  endproperty
  // pin drive follows a mode write, never a count
  property p_oe_write;
    $changed(module_io_oe) |-> wb_ack || $past(wb_ack) || $past(wb_ack, 2);
  endproperty
  property p_reset;
    disable iff (1'b0)
    rst |=> !irq && !wdt_reset && !wb_ack && module_io_oe == '0;
  endproperty
  a_answer: assert property (p_answer) else $error("ack timing");
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  a_dat_byte: assert property (p_dat_byte) else $error("upper data bits");
  a_hole: assert property (p_hole) else $error("unmapped read data");
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("wdt width");
  a_oe_write: assert property (p_oe_write) else $error("oe change");
  a_reset: assert property (p_reset) else $error("reset outputs");
endmodule
bind programmable_counter_array pca_props props_u (.core_clk, .rst, .wb_cyc,
  .wb_stb, .wb_we, .wb_adr, .wb_dat_o, .wb_ack, .irq, .wdt_reset,
  .module_io_oe);
`default_nettype wire

//--- tb/pin_model.sv
// Purpose: port 1 pins on the far side of the array
// Assumes: pin changes are far apart
// Notes:   a driven pin reads back what the array drives
`default_nettype none
module pin_model
  import pca_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic [num_chan-1:0] drive_out,
  input  wire logic [num_chan-1:0] drive_oe,
  input  wire logic [num_chan-1:0] far,
  output logic                     count_pin,
  output logic [num_chan-1:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial count_pin = 1'b0;
  assign pin_in = (drive_oe & drive_out) | (~drive_oe & far);
  // slow pulses so the synchroniser sees every edge
  task automatic pulse_count(input int k);
    repeat (k) begin
      count_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      count_pin <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

//--- tb/test_programmable_counter_array.sv
// Purpose: self-checking bench for the counter array
// Assumes: one-cycle register answer, registered outputs
// Notes:   timer 0 pulses give exact tick counts
`default_nettype none
module test_programmable_counter_array
  import pca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                core_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic                idle, timer0_overflow, irq, wdt_reset, ext_pin;
  logic [7:0]          wb_adr, q;
  logic [3:0]          wb_sel;
  logic [31:0]         wb_dat_i, wb_dat_o;
  logic [num_chan-1:0] module_io_in, module_io_out, module_io_oe, far;
  logic [15:0]         v, c;
  int                  bad_count, n_tests, cycles, wdt_seen, n, m;
  programmable_counter_array dut_u (.core_clk, .rst, .wb_cyc, .wb_stb, .wb_we,
    .wb_adr, .wb_sel, .wb_dat_i, .wb_dat_o, .wb_ack, .idle, .timer0_overflow,
    .external_count_input(ext_pin), .module_io_in, .module_io_out,
    .module_io_oe, .irq, .wdt_reset);
  pin_model pins_u (.core_clk, .drive_out(module_io_out),
    .drive_oe(module_io_oe), .far, .count_pin(ext_pin), .pin_in(module_io_in));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (wdt_reset === 1'b1) wdt_seen++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_i <= {24'h0, d};
    do @(posedge core_clk); while (wb_ack !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick0(input int k);
    repeat (k) begin
      timer0_overflow <= 1'b1;
      @(posedge core_clk);
      timer0_overflow <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  task automatic set_cnt(input logic [15:0] val);
    bus(1, cnt_lo_addr, val[7:0]);
    bus(1, cnt_hi_addr, val[15:8]);
  endtask
  function automatic logic [7:0] ctl(logic ovf, logic run, logic [4:0] ev);
    return {ovf, run, 1'b0, ev};
  endfunction
  // three ticks from v reach the compare value c
  task automatic cmp_run(input logic [7:0] b, md, top);
    v = 16'($urandom_range(16'hfff0, 0));
    c = v + 16'd3;
    set_cnt(v);
    bus(1, b + chan_low_off, c[7:0]);
    bus(1, b + chan_high_off, c[15:8]);
    bus(1, b, md);
    bus(1, mode_reg_addr, top);
    bus(1, ctrl_reg_addr, 8'h40);
    tick0(3);
    bus(0, ctrl_reg_addr, 0);
  endtask
  task automatic close_out();
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, idle, timer0_overflow} = '0;
    wb_adr = '0;
    wb_sel = 4'hf;
    wb_dat_i = '0;
    far = '0;
    void'($urandom(32'h25b8c835));
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    bus(1, 8'h10, 8'hff);
    for (int i = 0; i < 5; i++) begin
      bus(0, 8'(i * 4), 0);
      check(q, 0);
    end
    $display("test reset done");
    n = $urandom_range(8, 1);
    bus(1, mode_reg_addr, 8'h04);
    bus(1, ctrl_reg_addr, ctl(0, 1, 0));
    tick0(n);
    bus(1, ctrl_reg_addr, 8'h00);
    tick0(2);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n));
    m = $urandom_range(6, 1);
    bus(1, mode_reg_addr, 8'h06);
    bus(1, ctrl_reg_addr, 8'h40);
    pins_u.pulse_count(m);
    bus(1, ctrl_reg_addr, 8'h00);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n + m));
    $display("test sources done");
    idle <= 1'b1;
    bus(1, mode_reg_addr, 8'h84);
    bus(1, ctrl_reg_addr, 8'h40);
    tick0(3);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n + m));
    bus(1, mode_reg_addr, 8'h04);
    tick0(2);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n + m + 2));
    idle <= 1'b0;
    $display("test idle done");
    bus(1, ctrl_reg_addr, 8'h00);
    bus(1, mode_reg_addr, 8'h02);
    bus(1, ctrl_reg_addr, 8'h40);
    n = n + m + 2;
    m = $urandom_range(20, 1);
    // an even run window of 2m+4 edges holds exactly m+2 ticks
    repeat (2 * m + 1) @(posedge core_clk);
    bus(1, ctrl_reg_addr, 8'h00);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n + m + 2));
    n = n + m + 2;
    bus(1, mode_reg_addr, 8'h00);
    bus(1, ctrl_reg_addr, 8'h40);
    // 24 run edges give four ticks whatever the divider phase
    repeat (21) @(posedge core_clk);
    bus(1, ctrl_reg_addr, 8'h00);
    bus(0, cnt_lo_addr, 0);
    check(q, 8'(n + 4));
    bus(1, mode_reg_addr, 8'h04);
    bus(1, ctrl_reg_addr, 8'h40);
    $display("test dividers done");
    set_cnt(16'hffff);
    tick0(1);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, {1'b0, ctl(1, 1, 0)});
    bus(1, mode_reg_addr, 8'h05);
    tick0(2);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, {1'b1, ctl(1, 1, 0)});
    bus(1, ctrl_reg_addr, 8'h00);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, 0);
    $display("test overflow done");
    v = 16'($urandom);
    set_cnt(v);
    bus(1, mode_reg_addr, 8'h00);
    bus(1, chan_base_addr, 8'h21);
    far[0] <= 1'b1;
    repeat (8) @(posedge core_clk);
    bus(0, chan_base_addr + chan_low_off, 0);
    check(q, v[7:0]);
    bus(0, chan_base_addr + chan_high_off, 0);
    check(q, v[15:8]);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, {1'b1, ctl(0, 0, 5'h01)});
    bus(1, ctrl_reg_addr, 8'h00);
    bus(1, chan_base_addr, 8'h00);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, 0);
    c = ~v;
    set_cnt(c);
    bus(1, chan_base_addr, 8'h10);
    far[0] <= 1'b0;
    repeat (8) @(posedge core_clk);
    bus(0, chan_base_addr + chan_low_off, 0);
    check(q, c[7:0]);
    bus(0, ctrl_reg_addr, 0);
    check({irq, q}, {1'b0, ctl(0, 0, 5'h01)});
    bus(1, ctrl_reg_addr, 8'h00);
    $display("test capture done");
    wdt_seen = 0;
    cmp_run(8'h30, 8'h4c, 8'h44);
    check(q, ctl(0, 1, 5'h02));
    check({module_io_oe[1], module_io_out[1], 8'(wdt_seen)}, 10'h300);
    cmp_run(8'h60, 8'h48, 8'h44);
    check(16'(wdt_seen), 16'h0001);
    cmp_run(8'h60, 8'h48, 8'h04);
    check(16'(wdt_seen), 16'h0001);
    $display("test compare done");
    bus(1, 8'h48, 8'h5a);
    bus(1, 8'h40, 8'h42);
    set_cnt(16'h00ff);
    tick0(1);
    bus(0, 8'h44, 0);
    check(q, 8'h5a);
    check({module_io_oe[2], module_io_out[2]}, 2'b10);
    bus(1, cnt_lo_addr, 8'h60);
    check({module_io_oe[2], module_io_out[2]}, 2'b11);
    $display("test pwm done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({module_io_oe, module_io_out, irq, wdt_reset}, 0);
    bus(0, cnt_hi_addr, 0);
    check(q, cnt_reset[15:8]);
    bus(0, mode_reg_addr, 0);
    check(q, 0);
    bus(0, ctrl_reg_addr, 0);
    check(q, 0);
    $display("test reset again done");
    close_out();
  end
endmodule
`default_nettype wire
